// ### sao_pkg.sv
// Constants, field layouts and carrier types of the subtract execution unit.
// Assumes one core clock; software reaches the state over a plain register port.
//
// Operation
// - Register form decodes from upper bits 0101 0 plus base, width, modes, registers.
// - Register form writes base minus source to destination and sets five flags.
// - Base is direct; source and destination may use five indirect modes.
// - Width bit clear means word operation, set means byte operation.
// - Three-bit fields pick addressing modes; four-bit fields pick registers.
// - Every form is one word and finishes in one cycle.
// - Accumulator form decodes from 1100 1011 A011 and twelve zeros.
// - Selected accumulator minus the other, 40-bit result back into selected one.
// - Accumulator form changes only overflow and saturation flags.
// - File form decodes from 1011 0101 1, width, destination bit, 13-bit address.
// - File value minus work register zero minus borrow, to register or file.
// - Borrow is the inverse of the carry flag.
// - Default work register is working register zero.
// - Borrowing forms keep zero flag on zero result, clear it otherwise.
// - Literal form decodes from 1011 0001 1, width, 10-bit literal, register.
// - Register minus literal minus borrow back to register; software bounds literal.
// - Borrowing forms update half-width carry, negative, wrap, zero, carry flags.

package sao_pkg;

    // Opcode patterns
    localparam logic [4:0]  OP_RR_HI   = 5'h0A;         // 0101 0
    localparam logic [7:0]  OP_ACC_HI  = 8'hCB;         // 1100 1011
    localparam logic [2:0]  OP_ACC_MID = 3'h3;          // 011
    localparam logic [11:0] OP_ACC_LO  = 12'h000;
    localparam logic [8:0]  OP_FR_HI   = 9'h16B;        // 1011 0101 1
    localparam logic [8:0]  OP_LIT_HI  = 9'h163;        // 1011 0001 1
    localparam int          WIDTH_BIT  = 14;

    // Addressing mode codes
    localparam logic [2:0] MODE_DIR  = 3'h0;
    localparam logic [2:0] MODE_IND  = 3'h1;
    localparam logic [2:0] MODE_PINC = 3'h2;
    localparam logic [2:0] MODE_PDEC = 3'h3;
    localparam logic [2:0] MODE_INCP = 3'h4;
    localparam logic [2:0] MODE_DECP = 3'h5;

    // Status word bit positions
    localparam int SR_C = 0;
    localparam int SR_Z = 1;
    localparam int SR_OV = 2;
    localparam int SR_N = 3;
    localparam int SR_DC = 8;
    localparam int SR_SAB = 10;
    localparam int SR_OAB = 11;
    localparam int SR_SB = 12;
    localparam int SR_SA = 13;
    localparam int SR_OB = 14;
    localparam int SR_OA = 15;

    // Core control saturation enables
    localparam int CC_SAT_B = 6;
    localparam int CC_SAT_A = 7;

    // Reset values
    localparam logic [15:0] SR_RST = 16'h0000;
    localparam logic [15:0] CORE_CTL_RST = 16'h0000;

    // Accumulator clamp limits
    localparam logic [39:0] ACC_MAX = 40'h007FFFFFFF;
    localparam logic [39:0] ACC_MIN = 40'hFF80000000;

    // Register port map (word index)
    localparam logic [5:0] RA_WREG0 = 6'h00;
    localparam logic [5:0] RA_SR = 6'h10;
    localparam logic [5:0] RA_CORE_CTL = 6'h11;
    localparam logic [5:0] RA_FIRST_ACCUM_L = 6'h12;
    localparam logic [5:0] RA_FIRST_ACCUM_H = 6'h13;
    localparam logic [5:0] RA_FIRST_ACCUM_U = 6'h14;
    localparam logic [5:0] RA_SECOND_ACCUM_L = 6'h15;
    localparam logic [5:0] RA_SECOND_ACCUM_H = 6'h16;
    localparam logic [5:0] RA_SECOND_ACCUM_U = 6'h17;
    localparam logic [5:0] RA_MEM_PTR = 6'h18;
    localparam logic [5:0] RA_MEM_DATA = 6'h19;

    localparam int MEM_AW_DEF = 12;                     // 4096 words = 8192 bytes

    typedef struct packed {
        logic        valid;
        logic [23:0] word;
    } sao_instr_t;

    typedef struct packed {
        logic [5:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } sao_bus_req_t;

    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] ptr;
        logic        ind;
        logic        ok;
    } sao_ea_t;

    typedef struct packed {
        logic [15:0] res;
        logic        c;
        logic        dc;
        logic        ov;
        logic        n;
        logic        z;
    } sao_res_t;

    typedef struct packed {
        logic [15:0][15:0] w;
        logic [15:0]       sr;
        logic [15:0]       core_ctl;
        logic [39:0]       acc_a;
        logic [39:0]       acc_b;
        logic [15:0]       mem_ptr;
        logic [15:0]       rd_data;
        logic              done;
        logic              illegal;
    } sao_state_t;

    localparam sao_state_t STATE_RST = '{w: '0, sr: SR_RST, core_ctl: CORE_CTL_RST,
        acc_a: '0, acc_b: '0, mem_ptr: '0, rd_data: '0, done: 1'b0, illegal: 1'b0};

endpackage

// ### sao_subtract_alu.sv
// Subtract execution unit: working registers, accumulators, status and data memory.
// Assumes instructions arrive one per cycle from fetch on the core clock.
// Memory is word wide; a byte address picks its lane by bit 0.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module sao_subtract_alu #(
    parameter int MEM_AW = sao_pkg::MEM_AW_DEF
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    // Instruction issue
    input  wire sao_pkg::sao_instr_t   instr,
    output logic                       instr_done,
    output logic                       instr_illegal,
    // Register port
    input  wire sao_pkg::sao_bus_req_t bus_req,
    output logic [15:0]                rd_data,
    // Status view
    output logic [15:0]                status
);

    ////////////////////////////////////////////////////////////////////////////////////
    // State and memory

    sao_pkg::sao_state_t st;
    sao_pkg::sao_state_t next_st;

    // Kept out of the state struct so reset need not clear thousands of words
    logic [15:0]       mem [0:(1<<MEM_AW)-1];
    logic              mem_we;
    logic [MEM_AW-1:0] mem_idx;
    logic [15:0]       mem_wd;
    logic [1:0]        mem_be;

    ////////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Effective address and pointer update for one operand
    function automatic sao_pkg::sao_ea_t calc_ea(input logic [15:0] ptr,
                                                 input logic [2:0]  mode,
                                                 input logic [15:0] step);
        sao_pkg::sao_ea_t r;
        r.ea  = ptr;
        r.ptr = ptr;
        r.ind = 1'b1;
        r.ok  = 1'b1;
        // Pre-modes use the stepped pointer; post-modes use the old one
        case (mode)
            sao_pkg::MODE_DIR:  r.ind = 1'b0;
            sao_pkg::MODE_IND:  r.ind = 1'b1;
            sao_pkg::MODE_PINC: r.ptr = ptr + step;
            sao_pkg::MODE_PDEC: r.ptr = ptr - step;
            sao_pkg::MODE_INCP: begin
                r.ptr = ptr + step;
                r.ea  = r.ptr;
            end
            sao_pkg::MODE_DECP: begin
                r.ptr = ptr - step;
                r.ea  = r.ptr;
            end
            default:            r.ok = 1'b0;                  // Offset modes are not ours
        endcase
        return r;
    endfunction

    // Data memory read; odd byte address picks the high lane
    function automatic logic [15:0] mem_rd(input logic [15:0] ea, input logic bmode);
        logic [15:0] wv;
        wv = mem[ea[MEM_AW:1]];
        if (bmode) begin
            return {8'h00, (ea[0] ? wv[15:8] : wv[7:0])};
        end
        return wv;
    endfunction

    // a - b - borrow as a + ~b + carry, flags at the operating width
    function automatic sao_pkg::sao_res_t sub_op(input logic [15:0] a,
                                                 input logic [15:0] b,
                                                 input logic        cin,
                                                 input logic        bmode);
        sao_pkg::sao_res_t r;
        logic [16:0] sw;
        logic [8:0]  sb;
        logic [4:0]  sh;
        sw = {1'b0, a} + {1'b0, ~b} + {16'h0000, cin};
        sb = {1'b0, a[7:0]} + {1'b0, ~b[7:0]} + {8'h00, cin};
        sh = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        // Byte flags ignore the upper byte, so stale bits never leak in
        if (bmode) begin
            r.res = {8'h00, sb[7:0]};
            r.c   = sb[8];
            r.dc  = sh[4];
            r.n   = sb[7];
            r.ov  = (a[7] != b[7]) && (sb[7] != a[7]);
            r.z   = (sb[7:0] == 8'h00);
        end else begin
            r.res = sw[15:0];
            r.c   = sw[16];
            r.dc  = sb[8];
            r.n   = sw[15];
            r.ov  = (a[15] != b[15]) && (sw[15] != a[15]);
            r.z   = (sw[15:0] == 16'h0000);
        end
        return r;
    endfunction

    // Apply the five arithmetic flags; sticky zero only ever clears
    function automatic logic [15:0] put_flags(input logic [15:0]       sr,
                                              input sao_pkg::sao_res_t r,
                                              input logic              sticky);
        logic [15:0] o;
        o = sr;
        o[sao_pkg::SR_C]  = r.c;
        o[sao_pkg::SR_DC] = r.dc;
        o[sao_pkg::SR_N]  = r.n;
        o[sao_pkg::SR_OV] = r.ov;
        o[sao_pkg::SR_Z]  = sticky ? (sr[sao_pkg::SR_Z] & r.z) : r.z;
        return o;
    endfunction

    // Guard bits that are not a sign extension of bit 31
    // Bit 31 is included so a value just past 31 bits also counts
    function automatic logic guard_ovf(input logic [39:0] v);
        return !((v[39:31] == 9'h000) || (v[39:31] == 9'h1FF));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////
    // Decode

    logic        op_rr;
    logic        op_acc;
    logic        op_fr;
    logic        op_lit;
    logic        bmode;
    logic [15:0] step;
    logic        borrow_c;

    // Fixed bits keep the forms disjoint, so branch order does not change the result
    // Fixed opcode bits pick the form
    assign op_rr  = (instr.word[23:19] == sao_pkg::OP_RR_HI);
    assign op_acc = (instr.word[23:16] == sao_pkg::OP_ACC_HI)
                 && (instr.word[14:12] == sao_pkg::OP_ACC_MID)
                 && (instr.word[11:0] == sao_pkg::OP_ACC_LO);
    assign op_fr  = (instr.word[23:15] == sao_pkg::OP_FR_HI);
    assign op_lit = (instr.word[23:15] == sao_pkg::OP_LIT_HI);
    assign bmode  = instr.word[sao_pkg::WIDTH_BIT];
    assign step   = bmode ? 16'h0001 : 16'h0002;
    assign borrow_c = st.sr[sao_pkg::SR_C];    // Carry in = not borrow

    ////////////////////////////////////////////////////////////////////////////////////
    // Execute

    sao_pkg::sao_ea_t  ea_s;
    sao_pkg::sao_ea_t  ea_d;
    sao_pkg::sao_res_t sres;
    logic [15:0]       src_val;
    logic [15:0]       dst_ea;
    logic              dst_mem;
    logic [39:0]       acc_x;
    logic [39:0]       acc_y;
    logic [39:0]       acc_r;
    logic              acc_ov40;
    logic              acc_clamp;
    logic              acc_sat_en;

    // Whole instruction resolves in this cycle; memory is read here and written at the edge
    always_comb begin
        next_st         = st;
        next_st.done    = 1'b0;
        next_st.illegal = 1'b0;
        mem_we  = 1'b0;
        mem_idx = '0;
        mem_wd  = 16'h0000;
        mem_be  = 2'b00;
        ea_s    = '0;
        ea_d    = '0;
        sres    = '0;
        src_val = 16'h0000;
        dst_ea  = 16'h0000;
        dst_mem = 1'b0;
        acc_x   = instr.word[15] ? st.acc_b : st.acc_a;
        acc_y   = instr.word[15] ? st.acc_a : st.acc_b;
        acc_r   = acc_x - acc_y;
        acc_ov40  = (acc_x[39] != acc_y[39]) && (acc_r[39] != acc_x[39]);
        acc_clamp = 1'b0;
        // Saturation enable of the accumulator being written
        acc_sat_en = instr.word[15] ? st.core_ctl[sao_pkg::CC_SAT_B]
                                    : st.core_ctl[sao_pkg::CC_SAT_A];
        if (instr.valid) begin
            if (op_rr) begin
                ea_s = calc_ea(st.w[instr.word[3:0]], instr.word[6:4], step);
                // Destination mode check only; the real address is formed below
                ea_d = calc_ea(16'h0000, instr.word[13:11], step);
                if (!ea_s.ok || !ea_d.ok) begin
                    next_st.illegal = 1'b1;
                end else begin
                    // Source read uses the effective address formed from the register before any write-back
                    src_val = ea_s.ind ? mem_rd(ea_s.ea, bmode) : st.w[instr.word[3:0]];
                    next_st.w[instr.word[3:0]] = ea_s.ptr;
                    // Destination sees any source pointer step of the same register
                    ea_d = calc_ea(next_st.w[instr.word[10:7]], instr.word[13:11], step);
                    next_st.w[instr.word[10:7]] = ea_d.ptr;
                    sres = sub_op(st.w[instr.word[18:15]], src_val, 1'b1, bmode);
                    dst_mem = ea_d.ind;
                    dst_ea  = ea_d.ea;
                    if (!ea_d.ind) begin
                        next_st.w[instr.word[10:7]] = bmode
                            ? {next_st.w[instr.word[10:7]][15:8], sres.res[7:0]}
                            : sres.res;
                    end
                    next_st.sr   = put_flags(st.sr, sres, 1'b0);
                    next_st.done = 1'b1;
                end
            end else if (op_fr) begin
                // File value minus work register zero minus borrow
                sres = sub_op(mem_rd({3'b000, instr.word[12:0]}, bmode), st.w[0],
                              borrow_c, bmode);
                if (instr.word[13]) begin
                    dst_mem = 1'b1;
                    dst_ea  = {3'b000, instr.word[12:0]};
                end else begin
                    next_st.w[0] = bmode ? {st.w[0][15:8], sres.res[7:0]} : sres.res;
                end
                next_st.sr   = put_flags(st.sr, sres, 1'b1);
                next_st.done = 1'b1;
            end else if (op_lit) begin
                // Register minus literal minus borrow, back to the same register
                // Byte operation uses only the low eight literal bits
                sres = sub_op(st.w[instr.word[3:0]], {6'h00, instr.word[13:4]},
                              borrow_c, bmode);
                next_st.w[instr.word[3:0]] = bmode
                    ? {st.w[instr.word[3:0]][15:8], sres.res[7:0]} : sres.res;
                next_st.sr   = put_flags(st.sr, sres, 1'b1);
                next_st.done = 1'b1;
            end else if (op_acc) begin
                // Clamp on guard or full-width overflow when enabled
                if (acc_sat_en && (guard_ovf(acc_r) || acc_ov40)) begin
                    acc_clamp = 1'b1;
                    acc_r = ((acc_ov40 ? !acc_r[39] : acc_r[39]) ? sao_pkg::ACC_MIN
                                                                 : sao_pkg::ACC_MAX);
                end
                // A 40-bit signed wrap marks saturation even with clamping off
                if (instr.word[15]) begin
                    next_st.acc_b = acc_r;
                    if (acc_clamp || acc_ov40) next_st.sr[sao_pkg::SR_SB] = 1'b1;
                end else begin
                    next_st.acc_a = acc_r;
                    if (acc_clamp || acc_ov40) next_st.sr[sao_pkg::SR_SA] = 1'b1;
                end
                // Only overflow and saturation bits move
                next_st.sr[sao_pkg::SR_OA]  = guard_ovf(next_st.acc_a);
                next_st.sr[sao_pkg::SR_OB]  = guard_ovf(next_st.acc_b);
                next_st.sr[sao_pkg::SR_OAB] = next_st.sr[sao_pkg::SR_OA]
                                            | next_st.sr[sao_pkg::SR_OB];
                next_st.sr[sao_pkg::SR_SAB] = next_st.sr[sao_pkg::SR_SA]
                                            | next_st.sr[sao_pkg::SR_SB];
                next_st.done = 1'b1;
            end else begin
                next_st.illegal = 1'b1;
            end
            // Result store to memory, byte lane from the low address bit
            if (dst_mem) begin
                mem_we  = 1'b1;
                mem_idx = dst_ea[MEM_AW:1];
                mem_wd  = bmode ? {sres.res[7:0], sres.res[7:0]} : sres.res;
                mem_be  = bmode ? (dst_ea[0] ? 2'b10 : 2'b01) : 2'b11;
            end
        end else if (bus_req.wr) begin
            // Software writes only land in cycles with no instruction
            // A colliding write is lost, so software must write while idle
            if (bus_req.addr < sao_pkg::RA_SR) begin
                next_st.w[bus_req.addr[3:0]] = bus_req.wdata;
            end else begin
                case (bus_req.addr)
                    sao_pkg::RA_SR:       next_st.sr = bus_req.wdata;
                    sao_pkg::RA_CORE_CTL: next_st.core_ctl = bus_req.wdata;
                    sao_pkg::RA_FIRST_ACCUM_L:   next_st.acc_a[15:0] = bus_req.wdata;
                    sao_pkg::RA_FIRST_ACCUM_H:   next_st.acc_a[31:16] = bus_req.wdata;
                    sao_pkg::RA_FIRST_ACCUM_U:   next_st.acc_a[39:32] = bus_req.wdata[7:0];
                    sao_pkg::RA_SECOND_ACCUM_L:   next_st.acc_b[15:0] = bus_req.wdata;
                    sao_pkg::RA_SECOND_ACCUM_H:   next_st.acc_b[31:16] = bus_req.wdata;
                    sao_pkg::RA_SECOND_ACCUM_U:   next_st.acc_b[39:32] = bus_req.wdata[7:0];
                    sao_pkg::RA_MEM_PTR:  next_st.mem_ptr = bus_req.wdata;
                    sao_pkg::RA_MEM_DATA: begin
                        mem_we  = 1'b1;
                        mem_idx = st.mem_ptr[MEM_AW:1];
                        mem_wd  = bus_req.wdata;
                        mem_be  = 2'b11;
                    end
                    default: ;
                endcase
            end
        end
        // Read data shows the state before this cycle's update
        // Idle cycles return zero, so stale read data never lingers
        next_st.rd_data = 16'h0000;
        if (bus_req.rd) begin
            if (bus_req.addr < sao_pkg::RA_SR) begin
                next_st.rd_data = st.w[bus_req.addr[3:0]];
            end else begin
                case (bus_req.addr)
                    sao_pkg::RA_SR:       next_st.rd_data = st.sr;
                    sao_pkg::RA_CORE_CTL: next_st.rd_data = st.core_ctl;
                    sao_pkg::RA_FIRST_ACCUM_L:   next_st.rd_data = st.acc_a[15:0];
                    sao_pkg::RA_FIRST_ACCUM_H:   next_st.rd_data = st.acc_a[31:16];
                    sao_pkg::RA_FIRST_ACCUM_U:   next_st.rd_data = {8'h00, st.acc_a[39:32]};
                    sao_pkg::RA_SECOND_ACCUM_L:   next_st.rd_data = st.acc_b[15:0];
                    sao_pkg::RA_SECOND_ACCUM_H:   next_st.rd_data = st.acc_b[31:16];
                    sao_pkg::RA_SECOND_ACCUM_U:   next_st.rd_data = {8'h00, st.acc_b[39:32]};
                    sao_pkg::RA_MEM_PTR:  next_st.rd_data = st.mem_ptr;
                    sao_pkg::RA_MEM_DATA: next_st.rd_data = mem[st.mem_ptr[MEM_AW:1]];
                    default:              next_st.rd_data = 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Registers

    // All control state resets to constants
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= sao_pkg::STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // Data memory has no reset; contents are undefined until written
    always_ff @(posedge mclk) begin
        if (mem_we) begin
            if (mem_be[0]) mem[mem_idx][7:0] <= mem_wd[7:0];
            if (mem_be[1]) mem[mem_idx][15:8] <= mem_wd[15:8];
        end
    end

    // Outputs come straight from the state register, one edge after their cause
    assign instr_done    = st.done;
    assign instr_illegal = st.illegal;
    assign rd_data       = st.rd_data;
    assign status        = st.sr;

endmodule

// ### sao_subtract_alu_props.sv
// Checker for the subtract unit: decode, answer pulses and flag relations.
// Assumes it is bound to the unit's ports and sees only the core clock.
`timescale 1ns/1ps
module sao_subtract_alu_props (
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  reset_n,
    // Watched ports
    input wire sao_pkg::sao_instr_t   instr,
    input wire logic                  instr_done,
    input wire logic                  instr_illegal,
    input wire sao_pkg::sao_bus_req_t bus_req,
    input wire logic [15:0]           rd_data,
    input wire logic [15:0]           status
);
    logic is_rr, is_acc, is_fr, is_lit, bad_md;
    // Form decode; mode codes above five are refused by the unit
    assign is_rr  = instr.valid && (instr.word[23:19] == sao_pkg::OP_RR_HI);
    assign is_acc = instr.valid && (instr.word[23:16] == sao_pkg::OP_ACC_HI)
                    && (instr.word[14:0] == 15'h3000);
    assign is_fr  = instr.valid && (instr.word[23:15] == sao_pkg::OP_FR_HI);
    assign is_lit = instr.valid && (instr.word[23:15] == sao_pkg::OP_LIT_HI);
    assign bad_md = (instr.word[13:11] > 3'h5) || (instr.word[6:4] > 3'h5);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////
    rr_legal_a: assert property (is_rr && !bad_md |=> instr_done)
        else $error("register form not executed");
    rr_bad_mode_a: assert property (is_rr && bad_md
        |=> instr_illegal && $stable(status))
        else $error("bad mode not refused");
    acc_decode_a: assert property (is_acc |=> instr_done)
        else $error("accumulator form not executed");
    acc_flags_a: assert property (is_acc |=> status[9:0] == $past(status[9:0]))
        else $error("accumulator form touched other flags");
    borrow_decode_a: assert property (is_fr || is_lit |=> instr_done)
        else $error("borrowing form not executed");
    sticky_zero_a: assert property (is_fr || is_lit |=> !$rose(status[sao_pkg::SR_Z]))
        else $error("borrowing form set zero flag");
    one_answer_a: assert property (instr.valid |=> instr_done != instr_illegal)
        else $error("no single answer one cycle after issue");
    idle_quiet_a: assert property (!instr.valid |=> !instr_done && !instr_illegal)
        else $error("answer pulse without issue");
    illegal_hold_a: assert property (instr_illegal |-> status == $past(status))
        else $error("refused word changed status");
    // Main scenarios
    cover property (is_acc);
    cover property (is_fr);
    cover property (is_rr && bad_md);
endmodule
bind sao_subtract_alu sao_subtract_alu_props sao_subtract_alu_props_i (.mclk(mclk),
    .reset_n(reset_n), .instr(instr), .instr_done(instr_done),
    .instr_illegal(instr_illegal), .bus_req(bus_req), .rd_data(rd_data), .status(status));

// ### sao_subtract_alu_test.sv
// Testbench for the subtract unit: register port tasks and instruction sequences.
// Assumes the bound checker and the default memory size.
`timescale 1ns/1ps
module sao_subtract_alu_test;
    logic                  mclk;
    logic                  reset_n;
    sao_pkg::sao_instr_t   instr;
    sao_pkg::sao_bus_req_t bus_req;
    logic                  instr_done;
    logic                  instr_illegal;
    logic [15:0]           rd_data;
    logic [15:0]           status;
    int                    mismatches = 0;
    int                    check_count = 0;

    sao_subtract_alu sao_subtract_alu_i (.mclk(mclk), .reset_n(reset_n), .instr(instr),
        .instr_done(instr_done), .instr_illegal(instr_illegal), .bus_req(bus_req),
        .rd_data(rd_data), .status(status));
    ////////////////////
    // Core clock, 40 ns period
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Register port strobes last one cycle; read data stands only in the next
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req <= '0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [15:0] e);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req <= '0;
        #1 chk(rd_data, e);
    endtask
    // Accumulators travel as three words, the guard byte low in the third
    task automatic wacc(input logic [5:0] a, input logic [39:0] v);
        wr(a, v[15:0]);
        wr(a + 6'h01, v[31:16]);
        wr(a + 6'h02, {8'h00, v[39:32]});
    endtask
    task automatic racc(input logic [5:0] a, input logic [39:0] v);
        rdc(a, v[15:0]);
        rdc(a + 6'h01, v[31:16]);
        rdc(a + 6'h02, {8'h00, v[39:32]});
    endtask
    // One instruction; exactly one answer pulse in the following cycle
    task automatic run(input logic [23:0] w, input logic bad);
        @(posedge mclk);
        instr <= '{valid: 1'b1, word: w};
        @(posedge mclk);
        instr <= '0;
        #1 chk({14'h0000, instr_done, instr_illegal}, bad ? 16'h0001 : 16'h0002);
    endtask
    ////////////////////
    // Ceiling well above the roughly 150 cycles the sequence needs
    initial begin
        repeat (4000) @(posedge mclk);
        mismatches++;
        close_out();
    end
    // Main sequence; SR is set before most cases so flags are absolute
    initial begin
        reset_n = 1'b0;
        instr = '0;
        bus_req = '0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        wr(6'h00, 16'h1732);
        wr(6'h01, 16'h7844);
        run(24'h504001, 1'b0);
        rdc(6'h00, 16'h17EE);
        chk(status, 16'h0008);
        wr(6'h07, 16'h2450);
        wr(6'h08, 16'h1808);
        wr(6'h09, 16'h2020);
        wr(6'h18, 16'h1808);
        wr(6'h19, 16'h92E4);
        wr(6'h18, 16'h2020);
        wr(6'h19, 16'hA557);
        wr(6'h10, 16'h0000);
        run(24'h5394A8, 1'b0);
        rdc(6'h08, 16'h180A);
        rdc(6'h09, 16'h2022);
        rdc(6'h19, 16'h916C);
        chk(status, 16'h000C);
        wacc(sao_pkg::RA_FIRST_ACCUM_L, 40'h76120F098A);
        wacc(sao_pkg::RA_SECOND_ACCUM_L, 40'h23F312BC17);
        run(24'hCB3000, 1'b0);
        racc(sao_pkg::RA_FIRST_ACCUM_L, 40'h76120F098A - 40'h23F312BC17);
        chk(status, 16'hC80C);
        wacc(sao_pkg::RA_FIRST_ACCUM_L, 40'hFF90222EE1);
        wacc(sao_pkg::RA_SECOND_ACCUM_L, 40'h0024568F4C);
        wr(6'h11, 16'h0040);
        wr(6'h10, 16'h0000);
        run(24'hCBB000, 1'b0);
        racc(sao_pkg::RA_SECOND_ACCUM_L, 40'h007FFFFFFF);
        chk(status, 16'h1400);
        wr(6'h00, 16'h6234);
        wr(6'h18, 16'h0A04);
        wr(6'h19, 16'h6235);
        wr(6'h10, 16'h0000);
        run(24'hB58A04, 1'b0);
        rdc(6'h00, 16'h0000);
        chk(status, 16'h0101);
        wr(6'h00, 16'h0035);
        wr(6'h10, 16'h0003);
        run(24'hB5EA05, 1'b0);
        rdc(6'h19, 16'h2D35);
        chk(status, 16'h0001);
        wr(6'h00, 16'h7804);
        wr(6'h10, 16'h0000);
        run(24'hB1C230, 1'b0);
        rdc(6'h00, 16'h78E0);
        chk(status, 16'h0108);
        wr(6'h04, 16'h6234);
        wr(6'h10, 16'h0003);
        run(24'hB19084, 1'b0);
        rdc(6'h04, 16'h612C);
        chk(status, 16'h0101);
        run(24'h504061, 1'b1);
        run(24'hFFFFFF, 1'b1);
        chk(status, 16'h0101);
        run(24'h538CD8, 1'b0);
        rdc(6'h08, 16'h1808);
        wr(6'h18, 16'h2022);
        rdc(6'h19, 16'h916C);
        chk(status, 16'h000C);
        rdc(6'h3F, 16'h0000);
        close_out();
    end
endmodule
